// File: hdl/pts_pkg.sv
// package for the per-port ptp timestamp register set
package pts_pkg;

    // ********************************
    // register offsets (byte addresses)
    // ********************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_RX_LATENCY = 8'h00;
    localparam logic [7:0] OFS_TX_LATENCY = 8'h02;
    localparam logic [7:0] OFS_ASYMMETRY = 8'h04;
    localparam logic [7:0] OFS_REQ_STAMP_HI = 8'h08;
    localparam logic [7:0] OFS_REQ_STAMP_LO = 8'h0a;
    localparam logic [7:0] OFS_SYNC_STAMP_HI = 8'h0c;
    localparam logic [7:0] OFS_SYNC_STAMP_LO = 8'h0e;
    localparam logic [7:0] OFS_RESP_STAMP_HI = 8'h10;
    localparam logic [7:0] OFS_RESP_STAMP_LO = 8'h12;
    localparam logic [7:0] OFS_EVENT_FLAGS = 8'h14;
    localparam logic [7:0] OFS_EVENT_ENABLES = 8'h16;

    // ********************************
    // reset values and field positions
    // ********************************
    localparam logic [15:0] RX_LATENCY_RST = 16'h019f;
    localparam logic [15:0] TX_LATENCY_RST = 16'h002d;
    localparam logic [15:0] ASYMMETRY_RST = 16'h0000;
    localparam logic [31:0] STAMP_RST = 32'h0000_0000;
    localparam logic [2:0] FLAGS_RST = 3'h0;
    localparam logic [2:0] ENABLES_RST = 3'h0;
    localparam logic [15:0] RDATA_RST = 16'h0000;
    localparam int ASYM_SIGN_BIT = 15;
    localparam int ASYM_MAG_W = 15;
    localparam int EVT_LSB = 13;
    localparam int EVT_SYNC = 2;
    localparam int EVT_REQ = 1;
    localparam int EVT_RESP = 0;
    localparam int STAMP_HALF = 16;
    localparam int CORR_W = 64;
    localparam int CORR_FRAC_BITS = 16;

    // ********************************
    // message kinds and carriers
    // ********************************
    typedef enum logic [2:0] {
        PTS_MSG_SYNC,
        PTS_MSG_DELAY_REQ,
        PTS_MSG_PDELAY_REQ,
        PTS_MSG_PDELAY_RESP,
        PTS_MSG_OTHER
    } pts_msg_t;

    typedef enum logic [1:0] {
        PTS_ADJ_NONE,
        PTS_ADJ_ADD,
        PTS_ADJ_SUB
    } pts_adj_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } pts_reg_req_t;

    typedef struct packed {
        logic valid;
        pts_msg_t kind;
        logic [31:0] ns;
    } pts_stamp_evt_t;

    typedef struct packed {
        logic valid;
        logic egress;
        pts_msg_t kind;
        logic [63:0] field;
    } pts_corr_req_t;

    typedef struct packed {
        logic valid;
        logic [63:0] field;
    } pts_corr_rsp_t;

    typedef struct packed {
        logic [15:0] rx_latency;
        logic [15:0] tx_latency;
        logic [15:0] asymmetry;
        logic [31:0] req_stamp;
        logic [31:0] sync_stamp;
        logic [31:0] resp_stamp;
        logic [2:0] flags;
        logic [2:0] enables;
        logic [15:0] rdata;
        logic rvalid;
        logic irq_status;
        logic irq_enable;
        logic irq_req;
    } pts_regs_t;

    // ingress sync / pdelay_resp add, egress delay_req / pdelay_req subtract
    function automatic pts_adj_t adj_action(input logic egress, input pts_msg_t kind);
        pts_adj_t act;
        act = PTS_ADJ_NONE;
        if (!egress && (kind == PTS_MSG_SYNC || kind == PTS_MSG_PDELAY_RESP)) begin
            act = PTS_ADJ_ADD;
        end
        if (egress && (kind == PTS_MSG_DELAY_REQ || kind == PTS_MSG_PDELAY_REQ)) begin
            act = PTS_ADJ_SUB;
        end
        return act;
    endfunction

endpackage

// File: hdl/pts_asym_adjust.sv
// asymmetry correction applied to the ptp correction field
module pts_asym_adjust #(
    parameter int CORR_W = 64
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire pts_pkg::pts_corr_req_t req,
    input wire logic negative,
    input wire logic [14:0] magnitude,
    output pts_pkg::pts_corr_rsp_t rsp
);

    pts_pkg::pts_corr_rsp_t state;
    pts_pkg::pts_corr_rsp_t next_state;
    logic [CORR_W-1:0] scaled;
    logic [CORR_W-1:0] delta;
    pts_pkg::pts_adj_t act;

    always_comb begin
        // magnitude is whole ns, the field carries 16 fraction bits
        scaled = CORR_W'({magnitude, 16'h0000});
        delta = negative ? (~scaled + CORR_W'(1)) : scaled;
        act = pts_pkg::adj_action(req.egress, req.kind);
        next_state.valid = req.valid;
        next_state.field = req.field;
        case (act)
            pts_pkg::PTS_ADJ_ADD: begin
                next_state.field = req.field + delta;
            end
            pts_pkg::PTS_ADJ_SUB: begin
                next_state.field = req.field - delta;
            end
            default: begin
                next_state.field = req.field;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign rsp = state;

endmodule

// File: hdl/pts_port_regs.sv
// per-port ptp latency, asymmetry, egress timestamp and event register set

module pts_port_regs #(
    parameter int CORR_W = pts_pkg::CORR_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire pts_pkg::pts_reg_req_t reg_req,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    input wire pts_pkg::pts_stamp_evt_t stamp_evt,
    input wire pts_pkg::pts_corr_req_t corr_req,
    output pts_pkg::pts_corr_rsp_t corr_rsp,
    output logic [15:0] receive_path_delay,
    output logic [15:0] transmit_path_delay,
    output logic asymmetry_negative_flag,
    output logic [14:0] asymmetry_magnitude,
    output logic port_ptp_status,
    output logic port_ptp_enable,
    output logic port_ptp_irq
);

    // ********************************
    // local decode helpers
    // ********************************
    function automatic logic hit(input pts_pkg::pts_reg_req_t r, input logic [7:0] ofs);
        return r.addr == ofs;
    endfunction

    function automatic logic [15:0] evt_word(input logic [2:0] bits);
        // reserved low bits always read zero
        return {bits, 13'h0000};
    endfunction

    // ********************************
    // state
    // ********************************
    pts_pkg::pts_regs_t state;
    pts_pkg::pts_regs_t next_state;
    logic [2:0] set_evt;
    logic [2:0] clr_evt;
    logic [2:0] flags_n;
    logic [15:0] rd_word;
    logic wr;

    // ********************************
    // event decode
    // ********************************
    always_comb begin
        set_evt = 3'h0;
        if (stamp_evt.valid) begin
            case (stamp_evt.kind)
                pts_pkg::PTS_MSG_SYNC: begin
                    set_evt[pts_pkg::EVT_SYNC] = 1'b1;
                end
                pts_pkg::PTS_MSG_DELAY_REQ: begin
                    set_evt[pts_pkg::EVT_REQ] = 1'b1;
                end
                pts_pkg::PTS_MSG_PDELAY_REQ: begin
                    set_evt[pts_pkg::EVT_REQ] = 1'b1;
                end
                pts_pkg::PTS_MSG_PDELAY_RESP: begin
                    set_evt[pts_pkg::EVT_RESP] = 1'b1;
                end
                default: begin
                    set_evt = 3'h0;
                end
            endcase
        end
    end

    // ********************************
    // read mux
    // ********************************
    always_comb begin
        rd_word = 16'h0000;
        case (reg_req.addr)
            pts_pkg::OFS_RX_LATENCY: begin
                rd_word = state.rx_latency;
            end
            pts_pkg::OFS_TX_LATENCY: begin
                rd_word = state.tx_latency;
            end
            pts_pkg::OFS_ASYMMETRY: begin
                rd_word = state.asymmetry;
            end
            pts_pkg::OFS_REQ_STAMP_HI: begin
                rd_word = state.req_stamp[31:16];
            end
            pts_pkg::OFS_REQ_STAMP_LO: begin
                rd_word = state.req_stamp[15:0];
            end
            pts_pkg::OFS_SYNC_STAMP_HI: begin
                rd_word = state.sync_stamp[31:16];
            end
            pts_pkg::OFS_SYNC_STAMP_LO: begin
                rd_word = state.sync_stamp[15:0];
            end
            pts_pkg::OFS_RESP_STAMP_HI: begin
                rd_word = state.resp_stamp[31:16];
            end
            pts_pkg::OFS_RESP_STAMP_LO: begin
                rd_word = state.resp_stamp[15:0];
            end
            pts_pkg::OFS_EVENT_FLAGS: begin
                rd_word = evt_word(state.flags);
            end
            pts_pkg::OFS_EVENT_ENABLES: begin
                rd_word = evt_word(state.enables);
            end
            default: begin
                // unmapped offsets read as zero
                rd_word = 16'h0000;
            end
        endcase
    end

    // ********************************
    // next state
    // ********************************
    always_comb begin
        next_state = state;
        wr = reg_req.wr;
        clr_evt = 3'h0;

        // latency and asymmetry registers
        if (wr && hit(reg_req, pts_pkg::OFS_RX_LATENCY)) begin
            next_state.rx_latency = reg_req.wdata;
        end
        if (wr && hit(reg_req, pts_pkg::OFS_TX_LATENCY)) begin
            next_state.tx_latency = reg_req.wdata;
        end
        if (wr && hit(reg_req, pts_pkg::OFS_ASYMMETRY)) begin
            next_state.asymmetry = reg_req.wdata;
        end

        // enables, only the three event bits are writable
        if (wr && hit(reg_req, pts_pkg::OFS_EVENT_ENABLES)) begin
            next_state.enables = reg_req.wdata[15:13];
        end

        // write-one-to-clear flags
        if (wr && hit(reg_req, pts_pkg::OFS_EVENT_FLAGS)) begin
            clr_evt = reg_req.wdata[15:13];
        end

        // stamp capture; halves are not latched together, so a read
        // that straddles a new capture can mix two stamps
        if (set_evt[pts_pkg::EVT_SYNC]) begin
            next_state.sync_stamp = stamp_evt.ns;
        end
        if (set_evt[pts_pkg::EVT_REQ]) begin
            next_state.req_stamp = stamp_evt.ns;
        end
        if (set_evt[pts_pkg::EVT_RESP]) begin
            next_state.resp_stamp = stamp_evt.ns;
        end

        // set wins over a clear in the same cycle
        flags_n = (state.flags & ~clr_evt) | set_evt;
        next_state.flags = flags_n;

        // port level summaries follow the registered bits
        next_state.irq_status = |flags_n;
        next_state.irq_enable = |next_state.enables;
        next_state.irq_req = |(flags_n & next_state.enables);

        // read answer one cycle after the request
        next_state.rvalid = reg_req.rd;
        if (reg_req.rd) begin
            next_state.rdata = rd_word;
        end else begin
            next_state.rdata = pts_pkg::RDATA_RST;
        end
    end

    // ********************************
    // registers
    // ********************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state.rx_latency <= pts_pkg::RX_LATENCY_RST;
            state.tx_latency <= pts_pkg::TX_LATENCY_RST;
            state.asymmetry <= pts_pkg::ASYMMETRY_RST;
            state.req_stamp <= pts_pkg::STAMP_RST;
            state.sync_stamp <= pts_pkg::STAMP_RST;
            state.resp_stamp <= pts_pkg::STAMP_RST;
            state.flags <= pts_pkg::FLAGS_RST;
            state.enables <= pts_pkg::ENABLES_RST;
            state.rdata <= pts_pkg::RDATA_RST;
            state.rvalid <= 1'b0;
            state.irq_status <= 1'b0;
            state.irq_enable <= 1'b0;
            state.irq_req <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // ********************************
    // correction field datapath
    // ********************************
    pts_asym_adjust #(
        .CORR_W(CORR_W)
    ) u_adjust (
        .sys_clk(sys_clk),
        .rst(rst),
        .req(corr_req),
        .negative(state.asymmetry[pts_pkg::ASYM_SIGN_BIT]),
        .magnitude(state.asymmetry[14:0]),
        .rsp(corr_rsp)
    );

    // ********************************
    // outputs, all straight from flops
    // ********************************
    assign reg_rdata = state.rdata;
    assign reg_rvalid = state.rvalid;
    assign receive_path_delay = state.rx_latency;
    assign transmit_path_delay = state.tx_latency;
    assign asymmetry_negative_flag = state.asymmetry[pts_pkg::ASYM_SIGN_BIT];
    assign asymmetry_magnitude = state.asymmetry[14:0];
    assign port_ptp_status = state.irq_status;
    assign port_ptp_enable = state.irq_enable;
    assign port_ptp_irq = state.irq_req;

endmodule

// File: tb/pts_port_regs_assertions.sv
// concurrent checks on the port ptp register set ports
module pts_port_regs_assertions (
    input wire logic sys_clk,
    input wire logic rst,
    input wire pts_pkg::pts_reg_req_t reg_req,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire pts_pkg::pts_stamp_evt_t stamp_evt,
    input wire pts_pkg::pts_corr_req_t corr_req,
    input wire pts_pkg::pts_corr_rsp_t corr_rsp,
    input wire logic [15:0] receive_path_delay,
    input wire logic asymmetry_negative_flag,
    input wire logic [14:0] asymmetry_magnitude,
    input wire logic port_ptp_status,
    input wire logic port_ptp_enable,
    input wire logic port_ptp_irq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [63:0] mag;
    logic [63:0] d;
    assign mag = {33'h0, asymmetry_magnitude, 16'h0};
    assign d = asymmetry_negative_flag ? -mag : mag;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // ****************
    // properties
    // ****************
    property p_rx_wr;
        reg_req.wr && reg_req.addr == pts_pkg::OFS_RX_LATENCY
            |=> receive_path_delay == $past(reg_req.wdata);
    endproperty
    a_rx_wr: assert property (p_rx_wr) else $error("rx latency write lost");
    property p_add;
        corr_req.valid && !corr_req.egress && (corr_req.kind == pts_pkg::PTS_MSG_SYNC
            || corr_req.kind == pts_pkg::PTS_MSG_PDELAY_RESP)
            |=> corr_rsp.valid && corr_rsp.field == $past(corr_req.field) + $past(d);
    endproperty
    a_add: assert property (p_add) else $error("ingress add wrong");
    property p_sub;
        corr_req.valid && corr_req.egress && (corr_req.kind == pts_pkg::PTS_MSG_DELAY_REQ
            || corr_req.kind == pts_pkg::PTS_MSG_PDELAY_REQ)
            |=> corr_rsp.valid && corr_rsp.field == $past(corr_req.field) - $past(d);
    endproperty
    a_sub: assert property (p_sub) else $error("egress subtract wrong");
    property p_flag;
        stamp_evt.valid && stamp_evt.kind != pts_pkg::PTS_MSG_OTHER |=> port_ptp_status;
    endproperty
    a_flag: assert property (p_flag) else $error("stamp flag not set");
    property p_clear;
        reg_req.wr && reg_req.addr == pts_pkg::OFS_EVENT_FLAGS && reg_req.wdata[15:13] == 3'h7
            && !stamp_evt.valid |=> !port_ptp_status;
    endproperty
    a_clear: assert property (p_clear) else $error("status stuck");
    property p_en;
        reg_req.wr && reg_req.addr == pts_pkg::OFS_EVENT_ENABLES
            |=> port_ptp_enable == |$past(reg_req.wdata[15:13]);
    endproperty
    a_en: assert property (p_en) else $error("enable or wrong");
    property p_rsvd;
        reg_req.rd && reg_req.addr[7:2] == 6'h05 |=> reg_rvalid && reg_rdata[12:0] == 13'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    property p_irq;
        port_ptp_irq |-> port_ptp_status && port_ptp_enable;
    endproperty
    a_irq: assert property (p_irq) else $error("irq without cause");
endmodule
bind pts_port_regs pts_port_regs_assertions i_chk (.sys_clk(sys_clk), .rst(rst),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .stamp_evt(stamp_evt),
    .corr_req(corr_req), .corr_rsp(corr_rsp), .receive_path_delay(receive_path_delay),
    .asymmetry_negative_flag(asymmetry_negative_flag),
    .asymmetry_magnitude(asymmetry_magnitude), .port_ptp_status(port_ptp_status),
    .port_ptp_enable(port_ptp_enable), .port_ptp_irq(port_ptp_irq));

// File: tb/pts_egress_model.sv
// egress path stand-in issuing stamp events and correction fields
module pts_egress_model (
    input wire logic sys_clk,
    output pts_pkg::pts_stamp_evt_t stamp_evt,
    output pts_pkg::pts_corr_req_t corr_req
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        stamp_evt = '0;
        corr_req = '0;
    end
    // released ns, egress and field values carry inverted junk (kind is kept) so stale data cannot pass
    task automatic send_stamp(input pts_pkg::pts_msg_t k, input logic [31:0] ns);
        @(posedge sys_clk);
        #1;
        stamp_evt = {1'b1, k, ns};
        @(posedge sys_clk);
        #1;
        stamp_evt = {1'b0, k, ~ns};
    endtask
    task automatic send_corr(input logic eg, input pts_pkg::pts_msg_t k, input logic [63:0] f);
        @(posedge sys_clk);
        #1;
        corr_req = {1'b1, eg, k, f};
        @(posedge sys_clk);
        #1;
        corr_req = {1'b0, ~eg, k, ~f};
    endtask
endmodule

// File: tb/test_pts_port_regs.sv
// self-checking bench for the port ptp register set
module test_pts_port_regs;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk;
    logic rst;
    pts_pkg::pts_reg_req_t reg_req;
    logic [15:0] reg_rdata;
    logic reg_rvalid;
    pts_pkg::pts_stamp_evt_t stamp_evt;
    pts_pkg::pts_corr_req_t corr_req;
    pts_pkg::pts_corr_rsp_t corr_rsp;
    logic [15:0] rpd;
    logic [15:0] tpd;
    logic aneg;
    logic [14:0] amag;
    logic status;
    logic enable;
    logic irq;
    int errors = 0;
    int checked = 0;
    pts_port_regs i_dut (.sys_clk(sys_clk), .rst(rst), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .stamp_evt(stamp_evt),
        .corr_req(corr_req), .corr_rsp(corr_rsp), .receive_path_delay(rpd),
        .transmit_path_delay(tpd), .asymmetry_negative_flag(aneg), .asymmetry_magnitude(amag),
        .port_ptp_status(status), .port_ptp_enable(enable), .port_ptp_irq(irq));
    pts_egress_model i_far (.sys_clk(sys_clk), .stamp_evt(stamp_evt), .corr_req(corr_req));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // ****************
    // bus helpers
    // ****************
    task automatic step;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic check(input string n, input logic [63:0] s, input logic [63:0] e);
        checked++;
        if (s !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        step;
        reg_req = {1'b1, 1'b0, a, d};
        step;
        reg_req.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        step;
        reg_req = {1'b0, 1'b1, a, 16'h0};
        step;
        reg_req.rd = 1'b0;
        check("rvalid", reg_rvalid, 1'b1);
        check("rdata", reg_rdata, e);
    endtask
    task automatic do_reset;
        rst = 1'b1;
        repeat (8) @(posedge sys_clk);
        #1;
        rst = 1'b0;
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_reset;
        check("paths", {rpd, tpd}, 32'h019f_002d);
        rd(8'h00, 16'h019f);
        rd(8'h02, 16'h002d);
        rd(8'h04, 16'h0000);
        rd(8'h08, 16'h0000);
        rd(8'h0a, 16'h0000);
        rd(8'h0c, 16'h0000);
        rd(8'h0e, 16'h0000);
        rd(8'h10, 16'h0000);
        rd(8'h12, 16'h0000);
        rd(8'h14, 16'h0000);
        rd(8'h16, 16'h0000);
        check("port", {status, enable, irq}, 3'h0);
    endtask
    task automatic t_regs;
        wr(8'h00, 16'h1234);
        wr(8'h02, 16'hfedc);
        wr(8'h08, 16'hffff);
        wr(8'h04, 16'h8005);
        check("paths", {rpd, tpd}, 32'h1234_fedc);
        check("asym", {aneg, amag}, 16'h8005);
        rd(8'h02, 16'hfedc);
        rd(8'h04, 16'h8005);
        rd(8'h08, 16'h0000);
        rd(8'h06, 16'h0000);
    endtask
    task automatic t_corr(input logic [15:0] asym);
        logic [63:0] d;
        logic [63:0] e;
        d = {33'h0, asym[14:0], 16'h0};
        if (asym[15]) begin
            d = -d;
        end
        wr(8'h04, asym);
        for (int i = 0; i < 10; i++) begin
            e = 64'h0000_0001_0000_0000;
            if (i == 0 || i == 3) begin
                e = e + d;
            end
            if (i == 6 || i == 7) begin
                e = e - d;
            end
            i_far.send_corr(i >= 5, pts_pkg::pts_msg_t'(i % 5), 64'h0000_0001_0000_0000);
            check("corr", corr_rsp.field, e);
            check("corr valid", corr_rsp.valid, 1'b1);
        end
    endtask
    task automatic t_stamps;
        i_far.send_stamp(pts_pkg::PTS_MSG_SYNC, 32'h1111_2222);
        i_far.send_stamp(pts_pkg::PTS_MSG_DELAY_REQ, 32'h3333_4444);
        rd(8'h14, 16'hc000);
        rd(8'h08, 16'h3333);
        i_far.send_stamp(pts_pkg::PTS_MSG_PDELAY_REQ, 32'h5555_6666);
        i_far.send_stamp(pts_pkg::PTS_MSG_PDELAY_RESP, 32'h7777_8888);
        i_far.send_stamp(pts_pkg::PTS_MSG_OTHER, 32'h9999_aaaa);
        rd(8'h0c, 16'h1111);
        rd(8'h0e, 16'h2222);
        rd(8'h08, 16'h5555);
        rd(8'h0a, 16'h6666);
        rd(8'h10, 16'h7777);
        rd(8'h12, 16'h8888);
        rd(8'h14, 16'he000);
        check("port", {status, enable, irq}, 3'h4);
    endtask
    task automatic t_irq;
        wr(8'h16, 16'h3fff);
        check("port", {status, enable, irq}, 3'h7);
        rd(8'h16, 16'h2000);
        wr(8'h14, 16'h9fff);
        rd(8'h14, 16'h6000);
        wr(8'h14, 16'h2000);
        check("port", {status, enable, irq}, 3'h6);
        wr(8'h14, 16'h4000);
        check("port", {status, enable, irq}, 3'h2);
        wr(8'h16, 16'h0000);
        check("port", {status, enable, irq}, 3'h0);
        wr(8'h16, 16'he000);
        rd(8'h16, 16'he000);
        i_far.send_stamp(pts_pkg::PTS_MSG_SYNC, 32'h0);
        check("port", {status, enable, irq}, 3'h7);
        wr(8'h14, 16'he000);
        check("port", {status, enable, irq}, 3'h2);
        // event and clear on one edge: the event must win
        fork
            i_far.send_stamp(pts_pkg::PTS_MSG_SYNC, 32'h0000_0001);
            wr(8'h14, 16'h8000);
        join
        check("port", {status, enable, irq}, 3'h7);
        rd(8'h14, 16'h8000);
        rd(8'h0e, 16'h0001);
    endtask
    initial begin
        reg_req = '0;
        do_reset;
        t_reset;
        t_regs;
        t_corr(16'h8005);
        t_corr(16'h0007);
        t_stamps;
        t_irq;
        do_reset;
        t_reset;
        report_and_stop;
    end
    // whole run is under two hundred cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        report_and_stop;
    end
endmodule
